//--- hdl/siq_pkg.sv
// Shared constants, carriers and state layout of the signal input qualifier
package siq_pkg;
   localparam int CLK_HZ            = 100_000_000;
   localparam int SAMPLE_HZ         = 13_000;
   localparam int SAMPLE_CYCLES     = CLK_HZ / SAMPLE_HZ;
   localparam int DC_MIN_HZ         = 1_000;
   localparam int RED_EN_OLD_MS     = 100;
   localparam int RED_EN_NEW_MS     = 400;
   localparam int RED_EN_OLD_CYCLES = RED_EN_OLD_MS * (CLK_HZ / 1000);
   localparam int RED_EN_NEW_CYCLES = RED_EN_NEW_MS * (CLK_HZ / 1000);

   localparam int NUM_CHAN      = 18;
   localparam int NUM_LAMP      = 3 * NUM_CHAN;
   localparam int NUM_AC        = NUM_LAMP + 4;
   localparam int NUM_IN        = NUM_AC + 3;
   localparam int IDX_YELLOW0   = NUM_CHAN;
   localparam int IDX_RED0      = 2 * NUM_CHAN;
   localparam int IDX_RED_EN    = NUM_LAMP;
   localparam int IDX_COIL      = NUM_LAMP + 3;
   localparam logic [5:0] IDX_DC_SUPPLY = 6'd58;
   localparam logic [5:0] IDX_WATCHDOG  = 6'd59;
   localparam logic [5:0] IDX_EXT_RESET = 6'd60;
   localparam logic [5:0] IDX_LAST_AC   = 6'd57;

   // Sample code: 0.25 V per LSB, signed 11 bit
   localparam int CODE_PER_V   = 4;
   localparam int ON_LOW_V     = 25;
   localparam int OFF_LOW_V    = 15;
   localparam int ON_HIGH_V    = 70;
   localparam int OFF_HIGH_V   = 50;
   localparam logic [31:0] SQ_ON_LOW   = 32'((ON_LOW_V * CODE_PER_V) * (ON_LOW_V * CODE_PER_V));
   localparam logic [31:0] SQ_OFF_LOW  = 32'((OFF_LOW_V * CODE_PER_V) * (OFF_LOW_V * CODE_PER_V));
   localparam logic [31:0] SQ_ON_HIGH  = 32'((ON_HIGH_V * CODE_PER_V) * (ON_HIGH_V * CODE_PER_V));
   localparam logic [31:0] SQ_OFF_HIGH = 32'((OFF_HIGH_V * CODE_PER_V) * (OFF_HIGH_V * CODE_PER_V));
   localparam logic [9:0] DC_LOW_CODE    = 10'(4 * CODE_PER_V);
   localparam logic [9:0] DC_HIGH_CODE   = 10'(12 * CODE_PER_V);
   localparam logic [9:0] SUPPLY_MIN_CODE = 10'(20 * CODE_PER_V);
   localparam logic [9:0] SUPPLY_MAX_CODE = 10'(28 * CODE_PER_V);
   localparam logic [8:0] CNT_CAP        = 9'h100;

   localparam logic [11:0] REG_CTRL   = 12'h000;
   localparam logic [11:0] REG_STATUS = 12'h004;
   localparam logic [11:0] REG_VSEL   = 12'h008;
   localparam logic [11:0] REG_VDATA  = 12'h00c;
   localparam logic [11:0] REG_LOG_DC = 12'h010;
   localparam int CTRL_LED = 0;
   localparam int CTRL_SF2_EN = 1;
   localparam int CTRL_NEW_TIMING = 2;
   localparam int ST_MISSEAT = 7;

   localparam int SYNC_SIXTEEN = 0;
   localparam int SYNC_JUMPER  = 1;
   localparam int SYNC_SF1_INV = 2;
   localparam int SYNC_SF2_INV = 3;
   localparam int GATE_RED_EN  = 0;
   localparam int GATE_SF1     = 1;
   localparam int GATE_SF2     = 2;
   localparam int GATE_COIL    = 3;

   typedef enum logic [2:0] {PH_IDLE, PH_REQ, PH_WAIT, PH_ROLL, PH_CLASS} siq_phase_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } siq_apb_req_t;

   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } siq_apb_rsp_t;

   typedef struct packed {
      logic redFailEn;
      logic overlapEn;
      logic pedClearEn;
   } siq_check_en_t;

   typedef struct packed {
      siq_phase_t              phase;
      logic [15:0]             tickCnt;
      logic                    sampPend;
      logic                    linePend;
      logic [5:0]              idx;
      logic [NUM_AC-1:0][27:0] curSum;
      logic [NUM_AC-1:0][27:0] lastSum;
      logic [NUM_AC-1:0][28:0] winSum;
      logic [8:0]              curCnt;
      logic [8:0]              lastCnt;
      logic [8:0]              winCnt;
      logic [31:0]             limOnLo;
      logic [31:0]             limOffLo;
      logic [31:0]             limOnHi;
      logic [31:0]             limOffHi;
      logic [NUM_AC-1:0]       lowOn;
      logic [NUM_AC-1:0]       highOn;
      logic [2:0][9:0]         dcCode;
      logic                    dcOk;
      logic                    wdHigh;
      logic                    extRstActive;
      logic [3:0]              gateQual;
      logic [25:0]             persistCnt;
      logic [3:0]              syncA;
      logic [3:0]              syncB;
      logic [2:0]              ctrl;
      logic [5:0]              vsel;
      logic                    misseatFault;
      logic [29:0]             logDc;
      logic [31:0]             prdata;
      logic                    pslverr;
      logic [NUM_LAMP-1:0]     conflictView;
      logic [NUM_LAMP-1:0]     redFailView;
      siq_check_en_t           checkEn;
   } siq_state_t;
endpackage : siq_pkg

//--- hdl/siq_input_qualifier.sv
// Lamp, gating and DC input qualification with APB register access
`timescale 1ns/1ps
module siq_input_qualifier #(
   parameter int SAMPLE_PERIOD_CYCLES = siq_pkg::SAMPLE_CYCLES,
   parameter int RED_EN_OLD_CYCLES    = siq_pkg::RED_EN_OLD_CYCLES,
   parameter int RED_EN_NEW_CYCLES    = siq_pkg::RED_EN_NEW_CYCLES
) (
   input  wire logic                          clk_sys,
   input  wire logic                          reset_n,
   input  wire logic                          ce,
   input  wire siq_pkg::siq_apb_req_t         apbReq,
   output siq_pkg::siq_apb_rsp_t              apbRsp,
   output logic                               adcReq,
   output logic [5:0]                         adcChan,
   input  wire logic                          adcValid,
   input  wire logic signed [10:0]            adcData,
   input  wire logic                          lineCycleTick,
   input  wire logic                          linePowerValid,
   input  wire logic                          faultEvent,
   input  wire logic                          sixteenChanPin,
   input  wire logic                          overlapCheckAlwaysJumper,
   input  wire logic                          sf1InvertSwitch,
   input  wire logic                          sf2InvertSwitch,
   output logic [siq_pkg::NUM_LAMP-1:0]       conflictView,
   output logic [siq_pkg::NUM_LAMP-1:0]       redFailView,
   output siq_pkg::siq_check_en_t             checkEn,
   output logic [3:0]                         gateState,
   output logic                               dcSupplyOk,
   output logic                               watchdogHigh,
   output logic                               extResetActive,
   output logic                               cardMisseatedFlag,
   output logic                               conflictFlag
);
   siq_pkg::siq_state_t s;
   siq_pkg::siq_state_t next_s;

   logic        sampleTick;
   logic [9:0]  mag;
   logic [19:0] sqVal;
   logic [28:0] winNow;
   logic [8:0]  winCntNow;
   logic [3:0]  gateRaw;
   logic [25:0] persistLim;
   logic        apbSetup;
   logic        apbWrite;
   logic        misseatSet;
   logic        curLowBit;
   logic        curHighBit;

   // Hysteresis decision: on above, off below, hold between
   function automatic logic hyst(input logic prev, input logic onCond, input logic offCond);
      hyst = onCond ? 1'b1 : (offCond ? 1'b0 : prev);
   endfunction : hyst

   function automatic logic [9:0] magnitude(input logic signed [10:0] v);
      logic [10:0] a;
      a = v[10] ? 11'(-v) : 11'(v);
      magnitude = a[10] ? 10'h3ff : a[9:0];
   endfunction : magnitude

   assign sampleTick = (s.tickCnt == 16'(SAMPLE_PERIOD_CYCLES - 1));
   assign mag        = magnitude(adcData);
   assign sqVal      = 20'(mag * mag);
   assign winNow     = s.winSum[s.idx];
   assign curLowBit  = s.lowOn[s.idx];
   assign curHighBit = s.highOn[s.idx];
   assign winCntNow  = 9'(s.lastCnt + s.curCnt);
   assign persistLim = s.ctrl[siq_pkg::CTRL_NEW_TIMING] ? 26'(RED_EN_NEW_CYCLES - 1) : 26'(RED_EN_OLD_CYCLES - 1);
   assign apbSetup   = apbReq.psel && !apbReq.penable;
   assign apbWrite   = apbReq.psel && apbReq.penable && apbReq.pwrite && ce;

   always_comb begin
      next_s = s;
      misseatSet = 1'b0;
      gateRaw = 4'h0;
      next_s.syncA = {sf2InvertSwitch, sf1InvertSwitch, overlapCheckAlwaysJumper, sixteenChanPin};
      next_s.syncB = s.syncA;
      next_s.tickCnt = sampleTick ? 16'h0000 : 16'(s.tickCnt + 16'h0001);
      case (s.phase)
         siq_pkg::PH_IDLE: begin
            if (s.linePend) begin
               next_s.linePend = 1'b0;
               next_s.phase = siq_pkg::PH_ROLL;
            end else if (s.sampPend) begin
               next_s.sampPend = 1'b0;
               next_s.idx = 6'h00;
               next_s.phase = siq_pkg::PH_REQ;
            end
         end
         siq_pkg::PH_REQ: begin
            next_s.phase = siq_pkg::PH_WAIT;
         end
         siq_pkg::PH_WAIT: begin
            if (adcValid) begin
               if (s.idx <= siq_pkg::IDX_LAST_AC) begin
                  if (s.curCnt < siq_pkg::CNT_CAP) begin
                     next_s.curSum[s.idx] = 28'(s.curSum[s.idx] + {8'h00, sqVal});
                  end
               end else begin
                  next_s.dcCode[2'(s.idx - siq_pkg::IDX_DC_SUPPLY)] = mag;
               end
               if (s.idx == siq_pkg::IDX_DC_SUPPLY) begin
                  next_s.dcOk = (mag >= siq_pkg::SUPPLY_MIN_CODE) && (mag <= siq_pkg::SUPPLY_MAX_CODE);
               end
               if (s.idx == siq_pkg::IDX_WATCHDOG) begin
                  // Controller toggles this line; only its level is decided here
                  next_s.wdHigh = hyst(s.wdHigh, mag > siq_pkg::DC_HIGH_CODE, mag < siq_pkg::DC_LOW_CODE);
               end
               if (s.idx == siq_pkg::IDX_EXT_RESET) begin
                  next_s.extRstActive = !hyst(!s.extRstActive, mag > siq_pkg::DC_HIGH_CODE,
                                              mag < siq_pkg::DC_LOW_CODE);
                  if (s.curCnt < siq_pkg::CNT_CAP) begin
                     next_s.curCnt = 9'(s.curCnt + 9'h001);
                  end
                  next_s.phase = siq_pkg::PH_IDLE;
               end else begin
                  next_s.idx = 6'(s.idx + 6'h01);
                  next_s.phase = siq_pkg::PH_REQ;
               end
            end
         end
         siq_pkg::PH_ROLL: begin
            for (int i = 0; i < siq_pkg::NUM_AC; i++) begin
               next_s.winSum[i] = 29'({1'b0, s.lastSum[i]} + {1'b0, s.curSum[i]});
               next_s.lastSum[i] = s.curSum[i];
               next_s.curSum[i] = 28'h0000000;
            end
            next_s.winCnt = winCntNow;
            next_s.lastCnt = s.curCnt;
            next_s.curCnt = 9'h000;
            next_s.limOnLo = 32'(siq_pkg::SQ_ON_LOW * {23'h0, winCntNow});
            next_s.limOffLo = 32'(siq_pkg::SQ_OFF_LOW * {23'h0, winCntNow});
            next_s.limOnHi = 32'(siq_pkg::SQ_ON_HIGH * {23'h0, winCntNow});
            next_s.limOffHi = 32'(siq_pkg::SQ_OFF_HIGH * {23'h0, winCntNow});
            next_s.idx = 6'h00;
            next_s.phase = siq_pkg::PH_CLASS;
         end
         siq_pkg::PH_CLASS: begin
            if (s.winCnt != 9'h000) begin
               next_s.lowOn[s.idx] = hyst(curLowBit, {3'b000, winNow} > s.limOnLo,
                                          {3'b000, winNow} < s.limOffLo);
               next_s.highOn[s.idx] = hyst(curHighBit, {3'b000, winNow} > s.limOnHi,
                                           {3'b000, winNow} < s.limOffHi);
            end
            if (s.idx == siq_pkg::IDX_LAST_AC) begin
               next_s.phase = siq_pkg::PH_IDLE;
            end else begin
               next_s.idx = 6'(s.idx + 6'h01);
            end
         end
         default: begin
            next_s.phase = siq_pkg::PH_IDLE;
         end
      endcase
      // Pending events set after their clear so a coincident one is kept
      if (sampleTick) begin
         next_s.sampPend = 1'b1;
      end
      if (lineCycleTick) begin
         next_s.linePend = 1'b1;
      end

      // Gating inputs
      gateRaw[siq_pkg::GATE_RED_EN] = s.highOn[siq_pkg::IDX_RED_EN];
      gateRaw[siq_pkg::GATE_SF1] = s.highOn[siq_pkg::IDX_RED_EN + 1] ^ s.syncB[siq_pkg::SYNC_SF1_INV];
      gateRaw[siq_pkg::GATE_SF2] = (s.highOn[siq_pkg::IDX_RED_EN + 2] ^ s.syncB[siq_pkg::SYNC_SF2_INV])
                                   && s.ctrl[siq_pkg::CTRL_SF2_EN];
      gateRaw[siq_pkg::GATE_COIL] = s.highOn[siq_pkg::IDX_COIL];
      if (linePowerValid) begin
         next_s.gateQual[3:1] = gateRaw[3:1];
         if (gateRaw[siq_pkg::GATE_RED_EN] != s.gateQual[siq_pkg::GATE_RED_EN]) begin
            if (s.persistCnt >= persistLim) begin
               next_s.gateQual[siq_pkg::GATE_RED_EN] = gateRaw[siq_pkg::GATE_RED_EN];
               next_s.persistCnt = 26'h0;
            end else begin
               next_s.persistCnt = 26'(s.persistCnt + 26'h1);
            end
         end else begin
            next_s.persistCnt = 26'h0;
         end
      end else begin
         next_s.persistCnt = 26'h0;
      end

      // Per-check views of the lamp inputs
      for (int i = 0; i < siq_pkg::NUM_LAMP; i++) begin
         if (s.ctrl[siq_pkg::CTRL_LED]) begin
            next_s.conflictView[i] = s.lowOn[i];
            next_s.redFailView[i] = s.highOn[i];
         end else begin
            next_s.conflictView[i] = (i < siq_pkg::IDX_RED0) ? s.lowOn[i] : s.highOn[i];
            next_s.redFailView[i] = (i < siq_pkg::IDX_RED0) ? s.lowOn[i] : s.highOn[i];
         end
      end
      next_s.checkEn.redFailEn = s.gateQual[siq_pkg::GATE_RED_EN] && !s.gateQual[siq_pkg::GATE_SF1]
                                 && !s.gateQual[siq_pkg::GATE_SF2] && !s.gateQual[siq_pkg::GATE_COIL];
      next_s.checkEn.overlapEn = (s.gateQual[siq_pkg::GATE_RED_EN] || s.syncB[siq_pkg::SYNC_JUMPER])
                                 && !s.gateQual[siq_pkg::GATE_COIL];
      next_s.checkEn.pedClearEn = !s.gateQual[siq_pkg::GATE_COIL];

      // Green and yellow of channels 17 and 18 must stay dark in sixteen-channel mode
      misseatSet = s.syncB[siq_pkg::SYNC_SIXTEEN]
                   && (s.conflictView[siq_pkg::NUM_CHAN - 2] || s.conflictView[siq_pkg::NUM_CHAN - 1]
                       || s.conflictView[siq_pkg::IDX_RED0 - 2] || s.conflictView[siq_pkg::IDX_RED0 - 1]);
      if (faultEvent || misseatSet) begin
         next_s.logDc = {s.dcCode[2], s.dcCode[1], s.dcCode[0]};
      end

      // APB slave: read data staged in setup, write taken in access
      if (apbSetup) begin
         next_s.pslverr = 1'b0;
         next_s.prdata = 32'h00000000;
         case (apbReq.paddr)
            siq_pkg::REG_CTRL: next_s.prdata = {29'h0, s.ctrl};
            siq_pkg::REG_STATUS: begin
               next_s.prdata = {23'h0, linePowerValid, s.misseatFault, s.extRstActive, s.wdHigh, s.dcOk,
                                s.gateQual};
            end
            siq_pkg::REG_VSEL: next_s.prdata = {26'h0, s.vsel};
            siq_pkg::REG_VDATA: begin
               if (s.vsel <= siq_pkg::IDX_LAST_AC) begin
                  next_s.prdata = {3'b000, s.winSum[s.vsel]};
               end else if (s.vsel <= siq_pkg::IDX_EXT_RESET) begin
                  next_s.prdata = {22'h0, s.dcCode[2'(s.vsel - siq_pkg::IDX_DC_SUPPLY)]};
               end
            end
            siq_pkg::REG_LOG_DC: next_s.prdata = {2'b00, s.logDc};
            default: next_s.pslverr = 1'b1;
         endcase
      end
      if (apbWrite) begin
         case (apbReq.paddr)
            siq_pkg::REG_CTRL: next_s.ctrl = apbReq.pwdata[2:0];
            siq_pkg::REG_STATUS: begin
               if (apbReq.pwdata[siq_pkg::ST_MISSEAT]) begin
                  next_s.misseatFault = 1'b0;
               end
            end
            siq_pkg::REG_VSEL: next_s.vsel = apbReq.pwdata[5:0];
            default: next_s.vsel = s.vsel;
         endcase
      end
      if (misseatSet) begin
         next_s.misseatFault = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         s <= '0;
         s.wdHigh <= 1'b1;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign adcReq            = (s.phase == siq_pkg::PH_REQ) && ce;
   assign adcChan           = s.idx;
   assign apbRsp.pready     = apbReq.psel && apbReq.penable && ce;
   assign apbRsp.prdata     = s.prdata;
   assign apbRsp.pslverr    = s.pslverr;
   assign conflictView      = s.conflictView;
   assign redFailView       = s.redFailView;
   assign checkEn           = s.checkEn;
   assign gateState         = s.gateQual;
   assign dcSupplyOk        = s.dcOk;
   assign watchdogHigh      = s.wdHigh;
   assign extResetActive    = s.extRstActive;
   assign cardMisseatedFlag = s.misseatFault;
   assign conflictFlag      = s.misseatFault;

   a_scan_start: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ce && s.phase == siq_pkg::PH_IDLE && !s.linePend && s.sampPend |=> s.phase == siq_pkg::PH_REQ && s.idx == 6'h00)
      else $error("scan did not start on pending sample");
   a_window_roll: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ce && s.phase == siq_pkg::PH_ROLL |=> s.winSum[0] == 29'({1'b0, $past(s.lastSum[0])} + {1'b0, $past(s.curSum[0])})
      && s.curSum[0] == 28'h0 && s.phase == siq_pkg::PH_CLASS)
      else $error("window sum not formed from two cycles");
   a_square_acc: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ce && s.phase == siq_pkg::PH_WAIT && adcValid && s.idx == 6'h00 && s.curCnt < siq_pkg::CNT_CAP
      |=> s.curSum[0] == 28'($past(s.curSum[0]) + {8'h00, $past(sqVal)}))
      else $error("sample square not accumulated");
   a_class_on: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ce && s.phase == siq_pkg::PH_CLASS && s.winCnt != 9'h0 && {3'b000, winNow} > s.limOnLo
      |=> s.lowOn[$past(s.idx)])
      else $error("input above low on threshold not on");
   a_class_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ce && s.phase == siq_pkg::PH_CLASS && {3'b000, winNow} <= s.limOnHi && {3'b000, winNow} >= s.limOffHi
      |=> s.highOn[$past(s.idx)] == $past(curHighBit))
      else $error("state changed inside hysteresis band");
   a_led_views: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ce && s.ctrl[siq_pkg::CTRL_LED] |=> conflictView[siq_pkg::IDX_RED0] == $past(s.lowOn[siq_pkg::IDX_RED0]))
      else $error("led red conflict view not on low set");
   a_inc_red_view: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ce && !s.ctrl[siq_pkg::CTRL_LED] |=> conflictView[siq_pkg::IDX_RED0] == $past(s.highOn[siq_pkg::IDX_RED0]))
      else $error("incandescent red view not on high set");
   a_gate_freeze: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ce && !linePowerValid |=> s.gateQual == $past(s.gateQual))
      else $error("gating state changed without line power");
   a_overlap_off: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ce && !s.gateQual[siq_pkg::GATE_RED_EN] && !s.syncB[siq_pkg::SYNC_JUMPER] |=> !checkEn.overlapEn)
      else $error("overlap checks enabled with red enable off");
   a_sf2_ignore: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ce && linePowerValid && !s.ctrl[siq_pkg::CTRL_SF2_EN] |=> !s.gateQual[siq_pkg::GATE_SF2])
      else $error("second special function active while disabled");
   a_coil_block: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ce && s.gateQual[siq_pkg::GATE_COIL] |=> !checkEn.redFailEn && !checkEn.pedClearEn && !checkEn.overlapEn)
      else $error("coil on but checks still enabled");
   a_misseat_set: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ce && s.syncB[siq_pkg::SYNC_SIXTEEN] && s.conflictView[siq_pkg::NUM_CHAN - 1] |=> cardMisseatedFlag && conflictFlag)
      else $error("channel 18 green in sixteen mode not flagged");
   a_reset_low: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ce && s.phase == siq_pkg::PH_WAIT && adcValid && s.idx == siq_pkg::IDX_EXT_RESET && mag < siq_pkg::DC_LOW_CODE
      |=> extResetActive)
      else $error("low reset input not seen active");
   a_red_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ce && linePowerValid && gateRaw[siq_pkg::GATE_RED_EN] != s.gateQual[siq_pkg::GATE_RED_EN]
      && s.persistCnt < persistLim |=> s.gateQual[siq_pkg::GATE_RED_EN] == $past(s.gateQual[siq_pkg::GATE_RED_EN]))
      else $error("red enable taken before persistence");
   a_red_accept: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ce && linePowerValid && gateRaw[siq_pkg::GATE_RED_EN] != s.gateQual[siq_pkg::GATE_RED_EN]
      && s.persistCnt >= persistLim |=> s.gateQual[siq_pkg::GATE_RED_EN] == $past(gateRaw[siq_pkg::GATE_RED_EN]))
      else $error("red enable not taken after persistence");
   a_sf1_invert: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ce && linePowerValid
      |=> gateState[siq_pkg::GATE_SF1] == ($past(s.highOn[siq_pkg::IDX_RED_EN + 1]) ^ $past(s.syncB[siq_pkg::SYNC_SF1_INV])))
      else $error("first special function invert not applied");
   a_supply_band: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ce && s.phase == siq_pkg::PH_WAIT && adcValid && s.idx == siq_pkg::IDX_DC_SUPPLY
      |=> dcSupplyOk == ($past(mag) >= siq_pkg::SUPPLY_MIN_CODE && $past(mag) <= siq_pkg::SUPPLY_MAX_CODE))
      else $error("supply level not judged");
   a_wd_high: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ce && s.phase == siq_pkg::PH_WAIT && adcValid && s.idx == siq_pkg::IDX_WATCHDOG
      && mag > siq_pkg::DC_HIGH_CODE |=> watchdogHigh)
      else $error("high watchdog input not seen high");
   a_red_gate: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ce && !s.gateQual[siq_pkg::GATE_RED_EN]
      |=> !checkEn.redFailEn)
      else $error("dark check enabled without red enable");
   a_sf_block: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ce && (s.gateQual[siq_pkg::GATE_SF1] || s.gateQual[siq_pkg::GATE_SF2])
      |=> !checkEn.redFailEn)
      else $error("dark check enabled with special function on");
   a_fault_log: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ce && faultEvent
      |=> s.logDc == $past({s.dcCode[2], s.dcCode[1], s.dcCode[0]}))
      else $error("dc levels not logged on fault");
   a_tick_pend: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ce && sampleTick
      |=> s.sampPend)
      else $error("sample tick not pended");
endmodule : siq_input_qualifier

//--- test/siq_field_model.sv
// Field wiring and controller model answering sample requests
`timescale 1ns/1ps
module siq_field_model (
   input  wire logic              clk_sys,
   input  wire logic              adcReq,
   input  wire logic [5:0]        adcChan,
   input  wire logic [60:0][10:0] level,
   output logic                   adcValid,
   output logic signed [10:0]     adcData
);
   logic [1:0] waitCnt;
   logic [5:0] chan;
   logic       neg, slow, wdLow;
   initial begin
      {adcValid, adcData, waitCnt, chan, neg, slow, wdLow} = '0;
   end
   always @(posedge clk_sys) begin
      adcValid <= 1'b0;
      adcData <= ~adcData;
      if (adcReq) begin
         chan <= adcChan;
         waitCnt <= slow ? 2'd3 : 2'd1;
         slow <= !slow;
      end else if (waitCnt != 2'd0) begin
         waitCnt <= waitCnt - 2'd1;
         if (waitCnt == 2'd1) begin
            adcValid <= 1'b1;
            adcData <= (chan == 6'd59) ? (wdLow ? 11'h000 : 11'h060) : (neg ? -level[chan] : level[chan]);
            if (chan == 6'd59) wdLow <= !wdLow;
            neg <= !neg;
         end
      end
   end
endmodule : siq_field_model

//--- test/siq_input_qualifier_tb_top.sv
// Self-checking bench for the signal input qualifier
`timescale 1ns/1ps
module siq_input_qualifier_tb_top;
   logic                  clk_sys, reset_n, tick, powerOk, fault, pin16, aReq, aVal, ok, rstAct, mis;
   logic                  cf, wd, wdLast, jmp, inv1, inv2;
   logic [5:0]            aChan;
   logic signed [10:0]    aData;
   logic [60:0][10:0]     lvl;
   logic [53:0]           cv, rv, expv;
   logic [3:0]            gate;
   logic [32:0]           r;
   logic [31:0]           seed = 32'hdf2ef609;
   siq_pkg::siq_apb_req_t req;
   siq_pkg::siq_apb_rsp_t rsp;
   siq_pkg::siq_check_en_t en;
   int                    fails = 0, checks = 0, wdFlips = 0;
   siq_input_qualifier #(.SAMPLE_PERIOD_CYCLES(400), .RED_EN_OLD_CYCLES(20), .RED_EN_NEW_CYCLES(50)) dut (
      .clk_sys(clk_sys), .reset_n(reset_n), .ce(1'b1), .apbReq(req), .apbRsp(rsp), .adcReq(aReq), .adcChan(aChan),
      .adcValid(aVal), .adcData(aData), .lineCycleTick(tick), .linePowerValid(powerOk), .faultEvent(fault),
      .sixteenChanPin(pin16), .overlapCheckAlwaysJumper(jmp), .sf1InvertSwitch(inv1), .sf2InvertSwitch(inv2),
      .conflictView(cv), .redFailView(rv), .checkEn(en), .gateState(gate), .dcSupplyOk(ok), .watchdogHigh(wd),
      .extResetActive(rstAct), .cardMisseatedFlag(mis), .conflictFlag(cf));
   siq_field_model field (.clk_sys(clk_sys), .adcReq(aReq), .adcChan(aChan), .level(lvl), .adcValid(aVal),
      .adcData(aData));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   task automatic chk(input logic [63:0] seen, input logic [63:0] want);
      checks++;
      if (seen !== want) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, seen, want);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk_sys);
      req.penable <= 1'b1;
      do @(posedge clk_sys); while (rsp.pready !== 1'b1);
      r = {rsp.pslverr, rsp.prdata};
      req <= '0;
   endtask : apb
   always @(posedge clk_sys) begin
      wdLast <= wd;
      if (reset_n && wd !== wdLast) wdFlips++;
   end
   task automatic settle;
      repeat (3200) @(posedge clk_sys);
   endtask : settle
   task automatic stop_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test
   initial begin
      clk_sys = 0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      tick = 0;
      forever begin
         repeat (999) @(posedge clk_sys);
         tick <= 1'b1;
         @(posedge clk_sys);
         tick <= 1'b0;
      end
   end
   initial begin
      repeat (40000) @(posedge clk_sys);
      fails++;
      stop_test();
   end
   initial begin
      {req, reset_n, powerOk, fault, pin16, jmp, inv1, inv2} = 7'b0100010;
      for (int i = 0; i < 54; i++) begin
         seed = lfsr(seed);
         expv[i] = seed[0];
         lvl[i] = seed[0] ? 11'd320 : 11'd40;
      end
      lvl[60:54] = {11'd96, 11'd0, 11'd96, 11'd320, 11'd320, 11'd40, 11'd320};
      repeat (5) @(posedge clk_sys);
      reset_n <= 1'b1;
      chk(wd, 1'b1);
      settle();
      chk(cv, expv);
      chk(rv, expv);
      chk(gate, 4'b1011);
      chk(en, 3'b000);
      chk({ok, rstAct}, 2'b10);
      chk(wdFlips > 4, 1'b1);
      @(posedge clk_sys) fault <= 1'b1;
      @(posedge clk_sys) fault <= 1'b0;
      apb(1'b0, siq_pkg::REG_LOG_DC, 32'h0);
      chk(r[9:0], 10'd96);
      apb(1'b1, 12'h020, 32'h1);
      chk(r[32], 1'b1);
      $display("random lamp test done");
      powerOk <= 1'b0;
      lvl[57] <= 11'd40;
      for (int i = 0; i < 54; i++) lvl[i] <= 11'd160;
      apb(1'b1, siq_pkg::REG_CTRL, 32'h1);
      settle();
      chk(cv, {54{1'b1}});
      chk(rv, 54'h0);
      chk(gate, 4'b1011);
      $display("led threshold test done");
      powerOk <= 1'b1;
      pin16 <= 1'b1;
      apb(1'b1, siq_pkg::REG_CTRL, 32'h0);
      settle();
      chk(cv, {18'h0, {36{1'b1}}});
      chk(gate, 4'b0011);
      chk(en, 3'b011);
      chk({mis, cf}, 2'b11);
      for (int i = 0; i < 54; i++) lvl[i] <= 11'd80;
      {lvl[56], inv1, inv2} <= {11'd40, 2'b01};
      settle();
      chk(cv, {18'h0, {36{1'b1}}});
      chk(gate, 4'b0001);
      chk(en, 3'b111);
      apb(1'b1, siq_pkg::REG_CTRL, 32'h2);
      repeat (4) @(posedge clk_sys);
      chk(gate, 4'b0101);
      chk(en, 3'b011);
      $display("hysteresis test done");
      {lvl[54], lvl[60]} <= {11'd40, 11'd0};
      settle();
      chk({ok, rstAct}, 2'b11);
      chk(en, 3'b001);
      jmp <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk(en, 3'b011);
      $display("gating test done");
      stop_test();
   end
endmodule : siq_input_qualifier_tb_top
